// >>> sweep_pkg.sv
/*
 sweep_pkg: step codes, widths and depths, reset values and timing counts
 for the station sweep sequencer. assumes a 10 MHz mclk.
*/
package sweep_pkg;
	localparam int unsigned CLK_HZ          = 10_000_000;
	localparam int unsigned SYNC_TIMEOUT_S  = 5;
	localparam int unsigned SYNC_TIMEOUT_CYC = SYNC_TIMEOUT_S * CLK_HZ;
	localparam int unsigned SWEEP_IDX_W     = 4;
	localparam int unsigned GROUP_CNT       = 16;
	localparam int unsigned FIFO_DEPTH      = 16;
	localparam logic [3:0]  SWEEP_IDX_RST   = 4'h0;

	// backplane transfer kinds issued on the request port
	localparam logic [3:0] XF_READ_CONV    = 4'h1;
	localparam logic [3:0] XF_READ_PARAM   = 4'h2;
	localparam logic [3:0] XF_READ_GROUP   = 4'h3;
	localparam logic [3:0] XF_SYNC_GRP_OUT = 4'h4;
	localparam logic [3:0] XF_SYNC_PAR_OUT = 4'h5;
	localparam logic [3:0] XF_BUF_LOAD     = 4'h6;
	localparam logic [3:0] XF_BUF_TAKE     = 4'h7;
	localparam logic [3:0] XF_SYNC_PAR_IN  = 4'h8;
	localparam logic [3:0] XF_SYNC_GRP_IN  = 4'h9;
	localparam logic [3:0] XF_WRITE_CONV   = 4'hA;
	localparam logic [3:0] XF_WRITE_PARAM  = 4'hB;
	localparam logic [3:0] XF_WRITE_GROUP  = 4'hC;
	localparam logic [3:0] XF_BACKGROUND   = 4'hD;

	typedef enum logic [13:0] {
		ST_READ_CONV    = 14'h0001,
		ST_READ_PARAM   = 14'h0002,
		ST_READ_GROUP   = 14'h0004,
		ST_SYNC_GRP_OUT = 14'h0008,
		ST_SYNC_PAR_OUT = 14'h0010,
		ST_BUF_LOAD     = 14'h0020,
		ST_BUF_TAKE     = 14'h0040,
		ST_SYNC_PAR_IN  = 14'h0080,
		ST_SYNC_GRP_IN  = 14'h0100,
		ST_WRITE_CONV   = 14'h0200,
		ST_WRITE_PARAM  = 14'h0400,
		ST_WRITE_GROUP  = 14'h0800,
		ST_BACKGROUND   = 14'h1000,
		ST_WAIT         = 14'h2000
	} step_type;
endpackage

// >>> sweep_fifo.sv
/*
 sweep_fifo: synchronous valid/ready fifo, parameterised width and depth.
 assumes one clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
module sweep_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             mclk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("fifo depth must be a power of two, at least 2");
	end
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW:0]      wptr_ff;
	logic [AW:0]      rptr_ff;
	logic             push;
	logic             pop;

	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign in_ready  = (wptr_ff - rptr_ff) != (AW+1)'(DEPTH);
	assign out_valid = wptr_ff != rptr_ff;
	assign out_data  = mem_ff[rptr_ff[AW-1:0]];

	always_ff @(posedge mclk) begin
		if (push)
			mem_ff[wptr_ff[AW-1:0]] <= in_data;
	end
	always_ff @(posedge mclk) begin
		if (reset)
			wptr_ff <= '0;
		else if (push)
			wptr_ff <= wptr_ff + 1'b1;
	end
	always_ff @(posedge mclk) begin
		if (reset)
			rptr_ff <= '0;
		else if (pop)
			rptr_ff <= rptr_ff + 1'b1;
	end
endmodule

// >>> sweep_sequencer.sv
/*
 sweep_sequencer: repeating station sweep. each step attempt issues one request
 on the backplane request port, waits for done and merges returned data
 with forces and fault defaults. input words headed for the host pass the
 16-word fifo into the communications buffer port.
 assumes the backplane engine answers every request with one done pulse
 (plus ok/busy), data words arriving with the done of read steps.
*/
`timescale 1ns/1ps
// Summary of operation
// - sweep repeats forever, restarting after background
// - step one reads conventional inputs, merges forces
// - failed input read raises host fault report
// - hold-last-state module keeps last valid data
// - default module zeroes unforced, forced bits kept
// - analog inputs scaled, calibrated, alarm and range checked
// - step two reads intelligent parameters, same handling
// - step three reads scheduled groups to unit
// - sync module gets scheduled group data
// - sync module gets reference parameters from tables
// - network inputs copied into communications buffer
// - new host outputs merged with forces, stored
// - no bus outputs: defaults or hold, then forces
// - sync parameters retried while busy, five second timeout
// - sync group read, fault, zero or hold, forces
// - outputs sent, missing echo faults, defaults driven
// - analog outputs unscaled and range checked first
// - parameters to intelligent modules, contact failure faults
// - scheduled group moves to modules, failures fault
// - background tasks after all transfers
// - sync steps skipped without sync module
// - groups move every sweep or selected sweeps
module sweep_sequencer
	import sweep_pkg::*;
#(
	parameter int unsigned DATA_W      = 16,
	parameter int unsigned TIMEOUT_CYC = SYNC_TIMEOUT_CYC
) (
	input  wire logic                  mclk,
	input  wire logic                  reset,
	input  wire logic                  sync_present,
	input  wire logic                  hold_last_cfg,
	input  wire logic                  bus_outputs_live,
	input  wire logic [GROUP_CNT-1:0]  group_every_sweep,
	input  wire logic [GROUP_CNT*16-1:0] group_sweep_mask,
	input  wire logic [DATA_W-1:0]     force_mask,
	input  wire logic [DATA_W-1:0]     force_value,
	input  wire logic [DATA_W-1:0]     default_value,
	output logic                       xfer_req,
	output logic [3:0]                 xfer_kind,
	output logic [GROUP_CNT-1:0]       xfer_groups,
	output logic [DATA_W-1:0]          xfer_wdata,
	input  wire logic                  xfer_done,
	input  wire logic                  xfer_ok,
	input  wire logic                  xfer_busy,
	input  wire logic [DATA_W-1:0]     xfer_rdata,
	output logic [DATA_W-1:0]          table_word,
	output logic                       table_we,
	output logic                       fault_report,
	output logic                       cond_en,
	output logic                       out_unscale_en,
	output logic [DATA_W-1:0]          host_in_data,
	output logic                       host_in_valid,
	input  wire logic                  host_in_ready,
	input  wire logic [DATA_W-1:0]     host_out_data,
	output logic [3:0]                 sweep_index
);
	initial begin
		if (TIMEOUT_CYC < 1 || DATA_W < 1)
			$error("timeout and data width must be at least one");
	end

	step_type                  step_ff;
	step_type                  nxt_step;
	logic                      wait_ff;
	logic [SWEEP_IDX_W-1:0]    idx_ff;
	logic [31:0]               retry_ff;
	logic [DATA_W-1:0]         last_ff;
	logic                      req_ff;
	logic [3:0]                kind_ff;
	logic [GROUP_CNT-1:0]      grp_ff;
	logic [DATA_W-1:0]         wdata_ff;
	logic [DATA_W-1:0]         word_ff;
	logic                      we_ff;
	logic                      fault_ff;
	logic                      cond_ff;
	logic                      unscale_ff;
	logic [DATA_W-1:0]         hout_ff;
	logic                      hval_ff;
	logic [DATA_W-1:0]         fifo_wdata;
	logic                      fifo_wvalid;
	logic                      fifo_wready;
	logic [DATA_W-1:0]         fifo_rdata;
	logic                      fifo_rvalid;
	logic                      fifo_rready;
	logic [GROUP_CNT-1:0]      due;
	logic                      read_fail;
	logic                      timed_out;

	// unforced bits take src, forced bits keep their forced state
	function automatic logic [DATA_W-1:0] merge_force(
		input logic [DATA_W-1:0] src);
		merge_force = (src & ~force_mask) | (force_value & force_mask);
	endfunction

	// failed read: hold last valid word or zero, then reapply forces
	function automatic logic [DATA_W-1:0] fail_value(
		input logic [DATA_W-1:0] last);
		fail_value = merge_force(hold_last_cfg ? last : '0);
	endfunction

	// group due this sweep: every sweep, or its mask bit for the index
	always_comb begin
		for (int g = 0; g < GROUP_CNT; g++)
			due[g] = group_every_sweep[g] ||
				group_sweep_mask[g*16 + int'(idx_ff)];
	end

	assign read_fail = xfer_done && !xfer_ok && !xfer_busy;
	assign timed_out = retry_ff >= TIMEOUT_CYC - 1;

	// step order; sync steps fall through when absent
	function automatic step_type after(input step_type s);
		case (s)
			ST_READ_CONV:    after = ST_READ_PARAM;
			ST_READ_PARAM:   after = ST_READ_GROUP;
			ST_READ_GROUP:   after = sync_present ? ST_SYNC_GRP_OUT
			                                      : ST_BUF_LOAD;
			ST_SYNC_GRP_OUT: after = ST_SYNC_PAR_OUT;
			ST_SYNC_PAR_OUT: after = ST_BUF_LOAD;
			ST_BUF_LOAD:     after = ST_BUF_TAKE;
			ST_BUF_TAKE:     after = sync_present ? ST_SYNC_PAR_IN
			                                      : ST_WRITE_CONV;
			ST_SYNC_PAR_IN:  after = ST_SYNC_GRP_IN;
			ST_SYNC_GRP_IN:  after = ST_WRITE_CONV;
			ST_WRITE_CONV:   after = ST_WRITE_PARAM;
			ST_WRITE_PARAM:  after = ST_WRITE_GROUP;
			ST_WRITE_GROUP:  after = ST_BACKGROUND;
			ST_BACKGROUND:   after = ST_READ_CONV;
			default:         after = ST_READ_CONV;
		endcase
	endfunction

	function automatic logic [3:0] kind_of(input step_type s);
		case (s)
			ST_READ_CONV:    kind_of = XF_READ_CONV;
			ST_READ_PARAM:   kind_of = XF_READ_PARAM;
			ST_READ_GROUP:   kind_of = XF_READ_GROUP;
			ST_SYNC_GRP_OUT: kind_of = XF_SYNC_GRP_OUT;
			ST_SYNC_PAR_OUT: kind_of = XF_SYNC_PAR_OUT;
			ST_BUF_LOAD:     kind_of = XF_BUF_LOAD;
			ST_BUF_TAKE:     kind_of = XF_BUF_TAKE;
			ST_SYNC_PAR_IN:  kind_of = XF_SYNC_PAR_IN;
			ST_SYNC_GRP_IN:  kind_of = XF_SYNC_GRP_IN;
			ST_WRITE_CONV:   kind_of = XF_WRITE_CONV;
			ST_WRITE_PARAM:  kind_of = XF_WRITE_PARAM;
			ST_WRITE_GROUP:  kind_of = XF_WRITE_GROUP;
			default:         kind_of = XF_BACKGROUND;
		endcase
	endfunction

	// a step finishes on done, except a busy sync parameter read, which
	// is retried until the timeout lets it go
	always_comb begin
		nxt_step = step_ff;
		if (wait_ff && xfer_done) begin
			if (step_ff == ST_SYNC_PAR_IN && xfer_busy && !timed_out)
				nxt_step = step_ff;
			else
				nxt_step = after(step_ff);
		end
	end

	always_ff @(posedge mclk) begin
		if (reset)
			step_ff <= ST_READ_CONV;
		else
			step_ff <= nxt_step;
	end

	always_ff @(posedge mclk) begin
		if (reset)
			wait_ff <= 1'b0;
		else if (!wait_ff)
			wait_ff <= 1'b1;
		else if (xfer_done)
			wait_ff <= 1'b0;
	end

	// request issue, one pulse per attempt
	always_ff @(posedge mclk) begin
		if (reset) begin
			req_ff  <= 1'b0;
			kind_ff <= XF_BACKGROUND;
			grp_ff  <= '0;
		end else begin
			req_ff  <= !wait_ff;
			kind_ff <= kind_of(step_ff);
			grp_ff  <= (step_ff == ST_READ_GROUP ||
			            step_ff == ST_SYNC_GRP_OUT ||
			            step_ff == ST_WRITE_GROUP) ? due : '1;
		end
	end

	// outputs to modules carry forces; stale host data is replaced by the held or default word
	always_ff @(posedge mclk) begin
		if (reset)
			wdata_ff <= '0;
		else if (!bus_outputs_live)
			wdata_ff <= merge_force(hold_last_cfg ? last_ff
			                        : default_value);
		else
			wdata_ff <= merge_force(host_out_data);
	end

	always_ff @(posedge mclk) begin
		if (reset)
			retry_ff <= '0;
		else if (step_ff != ST_SYNC_PAR_IN)
			retry_ff <= '0;
		else if (!timed_out)
			retry_ff <= retry_ff + 1;
	end

	// table write-back of read-step and taken words; busy sync parameter reads before the timeout write nothing
	always_ff @(posedge mclk) begin
		if (reset) begin
			word_ff <= '0;
			we_ff   <= 1'b0;
		end else begin
			we_ff <= 1'b0;
			if (wait_ff && xfer_done) begin
				case (step_ff)
					ST_READ_CONV, ST_READ_PARAM, ST_READ_GROUP,
					ST_SYNC_PAR_IN, ST_SYNC_GRP_IN: begin
						we_ff <= !(xfer_busy && !timed_out);
						if (xfer_ok)
							word_ff <= merge_force(xfer_rdata);
						else
							word_ff <= fail_value(last_ff);
					end
					ST_BUF_TAKE: begin
						we_ff <= 1'b1;
						word_ff <= bus_outputs_live
							? merge_force(host_out_data)
							: merge_force(hold_last_cfg ? last_ff
							              : default_value);
					end
					default: we_ff <= 1'b0;
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset)
			last_ff <= '0;
		else if (wait_ff && xfer_done && xfer_ok)
			last_ff <= xfer_rdata;
	end

	// fault pulse for any failed read, write, echo or contact
	always_ff @(posedge mclk) begin
		if (reset)
			fault_ff <= 1'b0;
		else
			fault_ff <= wait_ff && (read_fail || (xfer_done && xfer_busy
				&& timed_out));
	end

	// conditioning strobes for the analog path
	always_ff @(posedge mclk) begin
		if (reset) begin
			cond_ff    <= 1'b0;
			unscale_ff <= 1'b0;
		end else begin
			cond_ff    <= step_ff == ST_READ_CONV;
			unscale_ff <= step_ff == ST_WRITE_CONV;
		end
	end

	// input words toward the host pass through the fifo; the load step
	// does not wait for space; a done into a full fifo drops its word
	assign fifo_wdata  = merge_force(xfer_rdata);
	assign fifo_wvalid = wait_ff && step_ff == ST_BUF_LOAD && xfer_done
		&& xfer_ok;
	assign fifo_rready = !hval_ff || host_in_ready;

	sweep_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.reset     (reset),
		.in_data   (fifo_wdata),
		.in_valid  (fifo_wvalid),
		.in_ready  (fifo_wready),
		.out_data  (fifo_rdata),
		.out_valid (fifo_rvalid),
		.out_ready (fifo_rready)
	);

	always_ff @(posedge mclk) begin
		if (reset) begin
			hval_ff <= 1'b0;
			hout_ff <= '0;
		end else if (fifo_rready) begin
			hval_ff <= fifo_rvalid;
			hout_ff <= fifo_rdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset)
			idx_ff <= SWEEP_IDX_RST;
		else if (wait_ff && xfer_done && step_ff == ST_BACKGROUND)
			idx_ff <= idx_ff + 1'b1;
	end

	assign xfer_req       = req_ff;
	assign xfer_kind      = kind_ff;
	assign xfer_groups    = grp_ff;
	assign xfer_wdata     = wdata_ff;
	assign table_word     = word_ff;
	assign table_we       = we_ff;
	assign fault_report   = fault_ff;
	assign cond_en        = cond_ff;
	assign out_unscale_en = unscale_ff;
	assign host_in_data   = hout_ff;
	assign host_in_valid  = hval_ff;
	assign sweep_index    = idx_ff;

	sequence background_done_s;
		step_ff == ST_BACKGROUND && wait_ff && xfer_done;
	endsequence

	restart_order_a: assert property (@(posedge mclk) disable iff (reset)
		background_done_s |=> step_ff == ST_READ_CONV)
		else $error("sweep did not restart after background");
	skip_sync_a: assert property (@(posedge mclk) disable iff (reset)
		!sync_present |-> step_ff != ST_SYNC_PAR_IN)
		else $error("sync step taken without sync module");
	index_wrap_a: assert property (@(posedge mclk) disable iff (reset)
		background_done_s |=> idx_ff == $past(idx_ff) + 4'h1)
		else $error("sweep index did not advance");
	fault_read_a: assert property (@(posedge mclk) disable iff (reset)
		wait_ff && read_fail |=> fault_report)
		else $error("failed read gave no fault");
	forced_keep_a: assert property (@(posedge mclk) disable iff (reset)
		we_ff && $stable(force_mask) && $stable(force_value) |->
		((word_ff ^ force_value) & force_mask) == '0)
		else $error("forced bits lost in table word");
	load_order_a: assert property (@(posedge mclk) disable iff (reset)
		step_ff == ST_BUF_LOAD && wait_ff && xfer_done
		|=> step_ff == ST_BUF_TAKE)
		else $error("outputs not taken after input load");
	retry_busy_a: assert property (@(posedge mclk) disable iff (reset)
		step_ff == ST_SYNC_PAR_IN && wait_ff && xfer_done && xfer_busy
		&& !timed_out |=> step_ff == ST_SYNC_PAR_IN ##1 xfer_req)
		else $error("busy sync module not retried");
	cond_step_a: assert property (@(posedge mclk) disable iff (reset)
		step_ff == ST_READ_CONV |=> cond_en)
		else $error("conditioning not applied to inputs");
	// a load done into a full fifo would drop its word; the engine must
	// hold such a done back
	load_space_a: assert property (@(posedge mclk) disable iff (reset)
		fifo_wvalid |-> fifo_wready)
		else $error("input word offered to a full fifo");
	sync_timeout_a: assert property (@(posedge mclk) disable iff (reset)
		step_ff == ST_SYNC_PAR_IN && wait_ff && xfer_done && xfer_busy
		&& timed_out |=> fault_report && table_we)
		else $error("sync timeout gave no fault or fail value");
endmodule

// >>> backplane_model.sv
/*
 backplane_model: far-side engine that answers each sequencer request
 with one done pulse after a latency chosen by the bench.
 assumes the bench supplies latency, data word and the ok/busy choices.
*/
`timescale 1ns/1ps
module backplane_model (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        xfer_req,
	input  wire logic [3:0]  xfer_kind,
	input  wire logic [2:0]  lat,
	input  wire logic        ok_cfg,
	input  wire logic [3:0]  busy_kind,
	input  wire logic [15:0] word,
	output logic             xfer_done,
	output logic             xfer_ok,
	output logic             xfer_busy,
	output logic [15:0]      xfer_rdata
);
	logic        pend_ff;
	logic        ok_ff;
	logic        busy_ff;
	logic [2:0]  cnt_ff;
	logic [15:0] data_ff;
	logic [15:0] junk_ff;

	// outside done the answer lines move every cycle, never hold data
	assign xfer_ok    = xfer_done ? ok_ff : junk_ff[0];
	assign xfer_busy  = xfer_done ? busy_ff : junk_ff[1];
	assign xfer_rdata = xfer_done ? data_ff : junk_ff;

	always_ff @(posedge mclk) begin
		junk_ff <= reset ? 16'h1E5B : ~junk_ff ^ 16'h5A3C;
	end

	// fifo is never left full by the bench, so load is answered freely
	always_ff @(posedge mclk) begin
		xfer_done <= 1'b0;
		if (reset) begin
			pend_ff <= 1'b0;
		end else if (xfer_req) begin
			pend_ff <= 1'b1;
			cnt_ff  <= lat;
		end else if (pend_ff && cnt_ff <= 3'h1) begin
			pend_ff   <= 1'b0;
			xfer_done <= 1'b1;
			ok_ff     <= ok_cfg && xfer_kind !== busy_kind;
			busy_ff   <= xfer_kind === busy_kind;
			data_ff   <= word;
		end else if (pend_ff) begin
			cnt_ff <= cnt_ff - 3'h1;
		end
	end
endmodule

// >>> io_station_sweep_sequencer_test.sv
/*
 io_station_sweep_sequencer_test: self-checking bench for the sweep
 sequencer and its fifo. assumes backplane_model as the far side.
*/
`timescale 1ns/1ps
module io_station_sweep_sequencer_test;
	import sweep_pkg::*;
	logic         mclk = 1'b0;
	logic         reset, sync_present, hold_last_cfg, bus_outputs_live;
	logic         xfer_req, xfer_done, xfer_ok, xfer_busy, table_we;
	logic         fault_report, cond_en, out_unscale_en, ok_cfg, fixed;
	logic         host_in_valid, host_in_ready, hold_rdy;
	logic         pend = 1'b0;
	logic         retry, dok, dbusy, skip;
	logic [2:0]   lat;
	logic [3:0]   xfer_kind, busy_kind, sweep_index, exp_kind, idx, dk;
	logic [15:0]  group_every_sweep, force_mask, force_value, default_value;
	logic [15:0]  host_out_data, word, xfer_groups, xfer_wdata, xfer_rdata;
	logic [15:0]  table_word, host_in_data, expw, last_good;
	logic [255:0] group_sweep_mask;
	logic [15:0]  q[$];
	int           n_errors = 0;
	int           compares = 0;
	int           seed = 75;
	int           bgc, fcnt, rcnt;

	always #50 mclk = ~mclk;

	sweep_sequencer #(.DATA_W(16), .TIMEOUT_CYC(20)) sweep_sequencer_i (
		.mclk(mclk), .reset(reset), .sync_present(sync_present),
		.hold_last_cfg(hold_last_cfg), .bus_outputs_live(bus_outputs_live),
		.group_every_sweep(group_every_sweep),
		.group_sweep_mask(group_sweep_mask), .force_mask(force_mask),
		.force_value(force_value), .default_value(default_value),
		.xfer_req(xfer_req), .xfer_kind(xfer_kind), .xfer_groups(xfer_groups),
		.xfer_wdata(xfer_wdata), .xfer_done(xfer_done), .xfer_ok(xfer_ok),
		.xfer_busy(xfer_busy), .xfer_rdata(xfer_rdata),
		.table_word(table_word), .table_we(table_we),
		.fault_report(fault_report), .cond_en(cond_en),
		.out_unscale_en(out_unscale_en), .host_in_data(host_in_data),
		.host_in_valid(host_in_valid), .host_in_ready(host_in_ready),
		.host_out_data(host_out_data), .sweep_index(sweep_index));

	backplane_model backplane_model_i (
		.mclk(mclk), .reset(reset), .xfer_req(xfer_req),
		.xfer_kind(xfer_kind), .lat(lat), .ok_cfg(ok_cfg),
		.busy_kind(busy_kind), .word(word), .xfer_done(xfer_done),
		.xfer_ok(xfer_ok), .xfer_busy(xfer_busy), .xfer_rdata(xfer_rdata));

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [15:0] mrg(input logic [15:0] v);
		return (v & ~force_mask) | (force_value & force_mask);
	endfunction

	// output word: host data, or hold/default when the bus is silent
	function automatic logic [15:0] outw();
		return mrg(bus_outputs_live ? host_out_data
			: hold_last_cfg ? last_good : default_value);
	endfunction

	function automatic logic [3:0] nxt(input logic [3:0] k);
		case (k)
		XF_READ_GROUP: return sync_present ? XF_SYNC_GRP_OUT : XF_BUF_LOAD;
		XF_BUF_TAKE:   return sync_present ? XF_SYNC_PAR_IN : XF_WRITE_CONV;
		XF_BACKGROUND: return XF_READ_CONV;
		default:       return k + 4'h1;
		endcase
	endfunction

	function automatic logic [15:0] due(input logic [3:0] i);
		for (int g = 0; g < 16; g++)
			due[g] = group_every_sweep[g] | group_sweep_mask[g*16 + i];
	endfunction

	// reference model of the sweep, sampled like a flop at each edge
	always @(posedge mclk) begin
		if (reset) begin
			exp_kind = XF_READ_CONV;
			idx = SWEEP_IDX_RST;
			pend = 1'b0;
			retry = 1'b0;
			last_good = 16'h0000;
			q.delete();
		end else begin
			if (pend) begin
				pend = 1'b0;
				if (!dbusy) check(16'(fault_report), 16'(!dok));
				if (dk === XF_READ_CONV) check(16'(table_we), 16'h0001);
				if (table_we === 1'b1 && !skip) check(table_word, expw);
			end
			if (fault_report === 1'b1) fcnt++;
			if (xfer_done === 1'b1) begin
				dk = xfer_kind;
				dok = xfer_ok;
				dbusy = xfer_busy;
				pend = 1'b1;
				skip = dbusy;
				if (dk === XF_BUF_TAKE)
					expw = outw();
				else
					expw = mrg(dok ? xfer_rdata
						: hold_last_cfg ? last_good : 16'h0000);
				if (dok) last_good = xfer_rdata;
				if (dok && dk === XF_BUF_LOAD) q.push_back(xfer_rdata);
				if (dk === XF_READ_CONV) check(16'(cond_en), 16'h0001);
				if (dk === XF_WRITE_CONV) check(16'(out_unscale_en), 16'h0001);
				if (dk === XF_BACKGROUND && !dbusy) begin
					idx = idx + 4'h1;
					bgc++;
				end
			end
			if (xfer_req === 1'b1) begin
				if (!(retry && xfer_kind === XF_SYNC_PAR_IN))
					check(16'(xfer_kind), 16'(exp_kind));
				check(16'(sweep_index), 16'(idx));
				if (xfer_kind === XF_READ_GROUP || xfer_kind === XF_WRITE_GROUP
					|| xfer_kind === XF_SYNC_GRP_OUT)
					check(xfer_groups, due(idx));
				else
					check(xfer_groups, 16'hFFFF);
				check(xfer_wdata, outw());
				retry = xfer_kind === XF_SYNC_PAR_IN && busy_kind === XF_SYNC_PAR_IN;
				if (xfer_kind === XF_SYNC_PAR_IN) rcnt++;
				exp_kind = nxt(xfer_kind);
			end
			if (host_in_valid === 1'b1 && host_in_ready === 1'b1)
				check(host_in_data, q.size() ? q.pop_front() : ~host_in_data);
		end
	end

	// load words are pre-forced so raw and merged readings agree
	always @(negedge mclk) begin : stim
		logic [15:0] r;
		r = 16'($random(seed));
		lat <= 3'(1 + ($random(seed) & 3));
		host_in_ready <= hold_rdy ? 1'b0 : 1'($random(seed));
		word <= fixed ? 16'h3C5A : (xfer_kind === XF_BUF_LOAD ? mrg(r) : r);
	end

	task automatic run(input string nm, input bit rs, input int n,
		input logic sy, ho, li, ok, input logic [3:0] bk, input logic [15:0] fm);
		@(negedge mclk);
		{sync_present, hold_last_cfg, bus_outputs_live, ok_cfg} <= {sy, ho, li, ok};
		busy_kind <= bk;
		force_mask <= fm;
		if (rs) begin
			reset <= 1'b1;
			force_value <= 16'($random(seed));
			default_value <= 16'($random(seed));
			host_out_data <= 16'($random(seed));
			group_every_sweep <= 16'($random(seed));
			for (int g = 0; g < 16; g++)
				group_sweep_mask[g*16 +: 16] <= 16'($random(seed));
			repeat (2) @(negedge mclk);
			check(16'(xfer_kind), 16'(XF_BACKGROUND));
			check(16'(xfer_req), 16'h0000);
			reset <= 1'b0;
		end
		{bgc, fcnt, rcnt} = '0;
		for (int t = 0; t < 3000 && bgc < n; t++) @(negedge mclk);
		check(16'(bgc), 16'(n));
		$display("test %s done", nm);
	endtask

	// host stalls for 16 sweeps: one word in the output stage, 15 queued
	task automatic fifo_test;
		hold_rdy = 1'b1;
		run("fifo_fill", 1, 16, 0, 0, 1, 1, 4'h0, 16'h0000);
		check(16'(host_in_valid), 16'h0001);
		hold_rdy = 1'b0;
		for (int t = 0; t < 300 && q.size() > 0; t++) @(negedge mclk);
		check(16'(q.size()), 16'h0000);
		check(16'(host_in_valid), 16'h0000);
		$display("test fifo done");
	endtask

	task automatic summarize;
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		reset = 1'b1;
		{sync_present, hold_last_cfg, bus_outputs_live, ok_cfg} = 4'h3;
		{fixed, hold_rdy, host_in_ready} = 3'h0;
		{lat, busy_kind} = {3'h1, 4'h0};
		{force_mask, force_value, default_value, host_out_data} = '0;
		{word, last_good, group_every_sweep} = '0;
		group_sweep_mask = '0;
		repeat (5) @(negedge mclk);
		run("plain", 1, 18, 0, 0, 1, 1, 4'h0, 16'h00F0);
		run("sync", 1, 3, 1, 0, 1, 1, 4'h0, 16'h0F0F);
		run("fail_zero", 1, 2, 1, 0, 1, 0, 4'h0, 16'hF00F);
		fixed = 1'b1;
		run("hold_ok", 1, 1, 0, 1, 1, 1, 4'h0, 16'h0000);
		run("hold_fail", 0, 2, 0, 1, 1, 0, 4'h0, 16'h0000);
		fixed = 1'b0;
		run("busy", 1, 2, 1, 0, 1, 1, XF_SYNC_PAR_IN, 16'h3300);
		check(16'(fcnt), 16'h0002);
		check(16'(rcnt > 2), 16'h0001);
		run("no_bus", 1, 2, 0, 0, 0, 1, 4'h0, 16'h0C30);
		fifo_test();
		summarize();
	end

	// sweeps take at most 110 cycles, busy sync ones included, so this is ample
	initial begin
		#2_000_000;
		n_errors++;
		$display("watchdog expired at %0t", $time);
		summarize();
	end
endmodule
